// ### src/iqi_pkg.sv
`default_nettype none
package iqi_pkg;
   // ----------------------------------------------------------------
   // register map (byte addresses on apb)
   // ----------------------------------------------------------------
   localparam int IQI_ADDR_W = 8;
   localparam logic [7:0] IQI_CTRL_OFS = 8'h00;
   localparam logic [7:0] IQI_GAIN_I_OFS = 8'h04;
   localparam logic [7:0] IQI_GAIN_Q_OFS = 8'h08;
   localparam logic [7:0] IQI_OFFS_I_OFS = 8'h0c;
   localparam logic [7:0] IQI_OFFS_Q_OFS = 8'h10;
   localparam logic [7:0] IQI_PHASE_OFS = 8'h14;
   localparam logic [7:0] IQI_STATUS_OFS = 8'h18;
   // field positions
   localparam int IQI_EN_BIT = 0;
   localparam int IQI_LIM_I_BIT = 1;
   localparam int IQI_LIM_Q_BIT = 2;
   localparam int IQI_OCC_LSB = 4;
   localparam int IQI_CODE_W = 6;
   // ----------------------------------------------------------------
   // arithmetic constants, q2.14 coefficients
   // ----------------------------------------------------------------
   localparam logic [17:0] IQI_UNITY = 18'h04000;
   localparam logic signed [19:0] IQI_FS = 20'sh07fff;
   localparam int IQI_GAIN_MAX = 12;
   localparam int IQI_PHASE_MAX = 20;
   localparam int IQI_LATENCY = 3;
   localparam int IQI_FIFO_DEPTH = 8;
   // linear gain for +k and -k half-db steps
   localparam logic [15:0] IQI_GAIN_POS [0:12] = '{16'h4000, 16'h43cb, 16'h47cf, 16'h4c10, 16'h5092, 16'h5558,
      16'h5a67, 16'h5fc2, 16'h656f, 16'h6b72, 16'h71cf, 16'h788e, 16'h7fb2};
   localparam logic [15:0] IQI_GAIN_NEG [0:12] = '{16'h4000, 16'h3c6c, 16'h390a, 16'h35d9, 16'h32d6, 16'h2ffe,
      16'h2d4f, 16'h2ac6, 16'h2862, 16'h261f, 16'h23fd, 16'h21fa, 16'h2013};
   // sine and cosine for k half-degree steps
   localparam logic [15:0] IQI_SIN_TAB [0:20] = '{16'h0000, 16'h008f, 16'h011e, 16'h01ad, 16'h023c, 16'h02cb,
      16'h0359, 16'h03e8, 16'h0477, 16'h0505, 16'h0594, 16'h0622, 16'h06b1, 16'h073f, 16'h07cd, 16'h085b,
      16'h08e8, 16'h0976, 16'h0a03, 16'h0a90, 16'h0b1d};
   localparam logic [15:0] IQI_COS_TAB [0:20] = '{16'h4000, 16'h3fff, 16'h3ffe, 16'h3ffa, 16'h3ff6, 16'h3ff0,
      16'h3fea, 16'h3fe1, 16'h3fd8, 16'h3fcd, 16'h3fc2, 16'h3fb5, 16'h3fa6, 16'h3f97, 16'h3f86, 16'h3f74,
      16'h3f61, 16'h3f4c, 16'h3f36, 16'h3f1f, 16'h3f07};
   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic signed [15:0] i;
      logic signed [15:0] q;
   } iqi_sample_s;
   typedef struct packed {
      logic signed [19:0] i;
      logic signed [19:0] q;
   } iqi_wide_s;
endpackage
`default_nettype wire

// ### src/iqi_datapath.sv
// Functional notes
// RL1: a master enable switch passes samples unchanged when off and applies gain, offset and phase when on.
// RL2: separate gains in half-db steps act on the in-phase and quadrature paths, imbalance being their db ratio.
// RL3: the db to linear conversion makes a one db step an amplitude change of about twelve percent.
// RL4: a positive in-phase gain scales i above q and a positive quadrature gain scales q above i.
// RL5: a signed dc offset in fractions of full scale is added to every i and every q sample, zero adding nothing.
// RL6: output never exceeds full scale, the offset being limited by the gain and the result saturated; the bypass passes -32768 unsaturated.
// RL7: the impaired i is i minus sine times q and the impaired q is cosine times q.
// RL8: a positive phase setting opens the i/q angle beyond ninety degrees, a negative one narrows it.
// RL9: coefficients are precomputed from the settings and applied with a fixed three-stage latency.
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// output fifo with registered head word
// ------------------------------------------------------------------
module iqi_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic ov;
      logic [WIDTH-1:0] od;
   } iqi_fifo_state_s;
   iqi_fifo_state_s st;
   iqi_fifo_state_s next_st;
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic wr_en;
   logic push;
   logic take;
   if (DEPTH < 2 || WIDTH < 1) begin : g_chk
      $error("fifo depth below two or empty width");
   end
   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction
   // full means every memory word is taken; the head register is extra
   assign in_ready_o = (st.cnt < (AW + 1)'(DEPTH));
   assign out_valid_o = st.ov;
   assign out_data_o = st.od;
   // head refill from memory first, else straight through when empty
   always_comb begin
      next_st = st;
      wr_en = 1'b0;
      push = in_valid_i & in_ready_o;
      take = ~st.ov | out_ready_i;
      if (take) begin
         if (st.cnt != '0) begin
            next_st.od = mem[st.rp];
            next_st.ov = 1'b1;
            next_st.rp = ptr_inc(st.rp);
            next_st.cnt = st.cnt - 1'b1;
         end else if (push) begin
            next_st.od = in_data_i;
            next_st.ov = 1'b1;
         end else begin
            next_st.ov = 1'b0;
         end
      end
      if (push && !(take && st.cnt == '0)) begin
         wr_en = 1'b1;
         next_st.wp = ptr_inc(st.wp);
         next_st.cnt = next_st.cnt + 1'b1;
      end
   end
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   // storage has no reset; only written words are ever read
   always_ff @(posedge clk_i) begin
      if (wr_en) begin
         mem[st.wp] <= in_data_i;
      end
   end
endmodule

// ------------------------------------------------------------------
// impairment datapath with apb settings
// ------------------------------------------------------------------
module iqi_datapath import iqi_pkg::*; #(
   parameter int FIFO_DEPTH = IQI_FIFO_DEPTH
) (
   input wire logic CLOCK_I,
   input wire logic RST_B_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [IQI_ADDR_W-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic IN_VALID_I,
   output logic IN_READY_O,
   input wire iqi_sample_s IN_SAMPLE_I,
   output logic OUT_VALID_O,
   input wire logic OUT_READY_I,
   output iqi_sample_s OUT_SAMPLE_O
);
   localparam int OCC_W = $clog2(FIFO_DEPTH + 2);
   if (FIFO_DEPTH < 2 || FIFO_DEPTH > 15) begin : g_chk
      $error("fifo depth must lie in 2 to 15");
   end

   typedef struct packed {
      logic en;
      logic [IQI_CODE_W-1:0] gcode_i;
      logic [IQI_CODE_W-1:0] gcode_q;
      logic signed [15:0] off_i;
      logic signed [15:0] off_q;
      logic [IQI_CODE_W-1:0] pcode;
      logic [17:0] gi;
      logic [17:0] gq;
      logic signed [17:0] sn;
      logic signed [17:0] cs;
      logic signed [16:0] oi;
      logic signed [16:0] oq;
      logic s1_v;
      iqi_sample_s s1_raw;
      iqi_wide_s s1;
      logic s2_v;
      iqi_sample_s s2_raw;
      iqi_wide_s s2;
      logic s3_v;
      iqi_sample_s s3;
      logic [OCC_W-1:0] occ;
      logic in_ready;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } iqi_state_s;
   iqi_state_s st;
   iqi_state_s next_st;
   logic acc;
   logic pop;
   logic fifo_ready;
   // ------------------------------------------------------------------
   // arithmetic helpers
   // ------------------------------------------------------------------
   function automatic logic [IQI_CODE_W-1:0] clamp_code(input logic [31:0] w, input int lim);
      logic signed [IQI_CODE_W-1:0] c;
      c = $signed(w[IQI_CODE_W-1:0]);
      if (c > lim) c = IQI_CODE_W'(lim);
      if (c < -lim) c = IQI_CODE_W'(-lim);
      return c;
   endfunction

   function automatic logic [17:0] gain_lin(input logic [IQI_CODE_W-1:0] code);
      logic signed [IQI_CODE_W-1:0] c;
      c = $signed(code);
      if (c < 0) return {2'b00, IQI_GAIN_NEG[4'(-c)]};
      return {2'b00, IQI_GAIN_POS[4'(c)]};
   endfunction

   function automatic logic signed [19:0] mulq(input logic signed [19:0] a, input logic signed [17:0] b);
      logic signed [37:0] p;
      p = a * b;
      return p[33:14];
   endfunction

   function automatic logic signed [19:0] sext(input logic signed [15:0] x);
      return {{4{x[15]}}, x};
   endfunction

   function automatic logic signed [15:0] sat16(input logic signed [19:0] x);
      if (x > IQI_FS) return IQI_FS[15:0];
      if (x < -IQI_FS) return 16'sh8001;
      return x[15:0];
   endfunction

   // offset headroom shrinks with gain so gain plus offset stays in full scale
   function automatic logic signed [16:0] lim_off(input logic signed [15:0] o, input logic [17:0] g);
      logic [31:0] p;
      logic signed [16:0] lim;
      logic signed [16:0] ox;
      p = 32'(IQI_FS[14:0]) * 32'(IQI_UNITY - g);
      lim = (g >= IQI_UNITY) ? 17'sh00000 : $signed({1'b0, p[29:14]});
      ox = {o[15], o};
      if (ox > lim) return lim;
      if (ox < -lim) return -lim;
      return ox;
   endfunction

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      next_st = st;
      acc = IN_VALID_I & st.in_ready;
      pop = OUT_VALID_O & OUT_READY_I;
      // apb: one wait-free access, answer prepared during setup
      next_st.pready = PSEL_I & ~PENABLE_I;
      next_st.pslverr = 1'b0;
      if (PSEL_I && !PENABLE_I) begin
         next_st.prdata = '0;
         unique case (PADDR_I)
            IQI_CTRL_OFS: next_st.prdata[IQI_EN_BIT] = st.en;
            IQI_GAIN_I_OFS: next_st.prdata = 32'($signed(st.gcode_i));
            IQI_GAIN_Q_OFS: next_st.prdata = 32'($signed(st.gcode_q));
            IQI_OFFS_I_OFS: next_st.prdata = 32'(st.off_i);
            IQI_OFFS_Q_OFS: next_st.prdata = 32'(st.off_q);
            IQI_PHASE_OFS: next_st.prdata = 32'($signed(st.pcode));
            IQI_STATUS_OFS: begin
               next_st.prdata[IQI_EN_BIT] = st.en;
               next_st.prdata[IQI_LIM_I_BIT] = (st.oi != {st.off_i[15], st.off_i});
               next_st.prdata[IQI_LIM_Q_BIT] = (st.oq != {st.off_q[15], st.off_q});
               next_st.prdata[IQI_OCC_LSB +: OCC_W] = st.occ;
            end
            default: next_st.pslverr = 1'b1;
         endcase
      end
      // writes land at the completing access edge; status is read-only
      if (PSEL_I && PENABLE_I && st.pready && PWRITE_I) begin
         unique case (PADDR_I)
            IQI_CTRL_OFS: next_st.en = PWDATA_I[IQI_EN_BIT]; // RL1
            IQI_GAIN_I_OFS: next_st.gcode_i = clamp_code(PWDATA_I, IQI_GAIN_MAX);
            IQI_GAIN_Q_OFS: next_st.gcode_q = clamp_code(PWDATA_I, IQI_GAIN_MAX);
            IQI_OFFS_I_OFS: next_st.off_i = PWDATA_I[15:0];
            IQI_OFFS_Q_OFS: next_st.off_q = PWDATA_I[15:0];
            IQI_PHASE_OFS: next_st.pcode = clamp_code(PWDATA_I, IQI_PHASE_MAX);
            default: next_st.en = st.en;
         endcase
      end
      // coefficients from settings, refreshed every cycle
      next_st.gi = gain_lin(st.gcode_i); // RL2 RL3 RL4 RL9
      next_st.gq = gain_lin(st.gcode_q); // RL2 RL4
      if ($signed(st.pcode) < 0) begin
         next_st.sn = -$signed({2'b00, IQI_SIN_TAB[5'(-$signed(st.pcode))]}); // RL8
         next_st.cs = $signed({2'b00, IQI_COS_TAB[5'(-$signed(st.pcode))]});
      end else begin
         next_st.sn = $signed({2'b00, IQI_SIN_TAB[5'(st.pcode)]}); // RL8
         next_st.cs = $signed({2'b00, IQI_COS_TAB[5'(st.pcode)]});
      end
      next_st.oi = lim_off(st.off_i, st.gi); // RL5 RL6
      next_st.oq = lim_off(st.off_q, st.gq); // RL5 RL6
      // stage 1: path gains
      next_st.s1_v = acc;
      next_st.s1_raw = IN_SAMPLE_I;
      next_st.s1.i = mulq(sext(IN_SAMPLE_I.i), $signed(st.gi)); // RL2
      next_st.s1.q = mulq(sext(IN_SAMPLE_I.q), $signed(st.gq)); // RL2
      // stage 2: quadrature skew
      next_st.s2_v = st.s1_v;
      next_st.s2_raw = st.s1_raw;
      next_st.s2.i = st.s1.i - mulq(st.s1.q, st.sn); // RL7
      next_st.s2.q = mulq(st.s1.q, st.cs); // RL7
      // stage 3: offset and saturation, or untouched samples when off
      next_st.s3_v = st.s2_v; // RL9
      if (st.en) begin
         next_st.s3.i = sat16(st.s2.i + {{3{st.oi[16]}}, st.oi}); // RL5 RL6
         next_st.s3.q = sat16(st.s2.q + {{3{st.oq[16]}}, st.oq}); // RL5 RL6
      end else begin
         next_st.s3 = st.s2_raw; // RL1
      end
      // credit count: pipeline plus fifo can never overrun
      next_st.occ = st.occ + OCC_W'(acc) - OCC_W'(pop);
      next_st.in_ready = (next_st.occ < OCC_W'(FIFO_DEPTH));
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign PRDATA_O = st.prdata;
   assign PREADY_O = st.pready;
   assign PSLVERR_O = st.pslverr;
   assign IN_READY_O = st.in_ready;

   iqi_fifo #(
      .WIDTH($bits(iqi_sample_s)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(CLOCK_I),
      .rst_b_i(RST_B_I),
      .in_valid_i(st.s3_v),
      .in_ready_o(fifo_ready),
      .in_data_i(st.s3),
      .out_valid_o(OUT_VALID_O),
      .out_ready_i(OUT_READY_I),
      .out_data_o(OUT_SAMPLE_O)
   );

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_B_I);

   bypass_pass_a: assert property ((acc && !st.en) ##1 !st.en ##1 !st.en |=> // RL1
      st.s3_v && st.s3 == $past(IN_SAMPLE_I, 3)) else $error("bypass altered a sample");
   unity_gain_a: assert property (st.gcode_i == '0 |=> st.gi == IQI_UNITY) // RL2
      else $error("zero db gain not unity");
   db_step_a: assert property (st.gcode_q == 6'h02 |=> st.gq == 18'h047cf) // RL3
      else $error("one db step wrong");
   gain_order_a: assert property ($signed(st.gcode_i) > $signed(st.gcode_q) |=> st.gi > st.gq) // RL4
      else $error("larger i gain not larger");
   zero_offset_a: assert property (st.off_i == '0 |=> st.oi == '0) // RL5
      else $error("zero offset added something");
   offset_limit_a: assert property (st.gq >= IQI_UNITY |=> st.oq == '0) // RL6
      else $error("offset allowed above full scale");
   full_scale_a: assert property (st.s2_v && st.en |=> st.s3.i != 16'sh8000 && st.s3.q != 16'sh8000) // RL6
      else $error("output beyond full scale");
   phase_ident_a: assert property (st.s1_v && st.sn == '0 && st.cs == IQI_UNITY |=> // RL7
      st.s2 == $past(st.s1)) else $error("zero phase changed the sample");
   phase_sign_a: assert property ($signed(st.pcode) > 0 |=> st.sn > 0 && st.cs < $signed(IQI_UNITY)) // RL8
      else $error("positive phase sign wrong");
   fixed_latency_a: assert property (acc |-> ##3 st.s3_v) // RL9
      else $error("sample latency not three");
   no_overrun_a: assert property (st.s3_v |-> fifo_ready)
      else $error("fifo overrun");
   apb_ready_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
      else $error("apb access not ready");

   bypass_c: cover property (acc && !st.en);
   saturate_c: cover property (st.s3_v && st.en && st.s3.i == IQI_FS[15:0]);
   fifo_full_c: cover property (!st.in_ready ##1 pop);
   apb_write_c: cover property (PSEL_I && PENABLE_I && PWRITE_I && PREADY_O);
endmodule
`default_nettype wire

// ### sim/iqi_stream_partner.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// waveform source and output sink around the datapath
// ------------------------------------------------------------------
module iqi_stream_partner import iqi_pkg::*; (
   input wire logic clk_i,
   input wire logic stall_i,
   input wire logic in_ready_i,
   output logic in_valid_o,
   output iqi_sample_s in_sample_o,
   input wire logic out_valid_i,
   input wire iqi_sample_s out_sample_i,
   output logic out_ready_o
);
   iqi_sample_s tx_q[$];
   iqi_sample_s rx_q[$];

   // idle at time zero
   initial begin
      in_valid_o = 1'b0;
      in_sample_o = '0;
      out_ready_o = 1'b0;
   end

   // source holds a word until taken; idle data toggles so stale words never look valid
   always @(posedge clk_i) begin
      if (in_valid_o && in_ready_i === 1'b1) begin
         void'(tx_q.pop_front());
      end
      if (tx_q.size() > 0) begin
         in_valid_o <= 1'b1;
         in_sample_o <= tx_q[0];
      end else begin
         in_valid_o <= 1'b0;
         in_sample_o <= ~in_sample_o;
      end
   end

   // sink collects every popped word, stalls on request
   always @(posedge clk_i) begin
      if (out_valid_i === 1'b1 && out_ready_o) begin
         rx_q.push_back(out_sample_i);
      end
      out_ready_o <= !stall_i;
   end
endmodule
`default_nettype wire

// ### sim/iqi_datapath_bench.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// self-checking bench for the impairment datapath
// ------------------------------------------------------------------
module iqi_datapath_bench import iqi_pkg::*; ;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic pready, pslverr, in_valid, in_ready, out_valid, out_ready;
   iqi_sample_s in_sample, out_sample;
   logic [31:0] exp_q[$];
   int n_fail = 0, checks = 0, en = 0, cgi = 0, cgq = 0, ofi = 0, ofq = 0, ph = 0, n;
   // settings rows: enable, gain i, gain q, offset i, offset q, phase
   int rows [7][6] = '{'{0, 4, 0, 0, 0, 6}, '{1, 0, 0, 0, 0, 0}, '{1, 2, 0, 0, 0, 0}, '{1, -3, 2, 0, 0, 0},
      '{1, -12, -12, 1000, -1500, 0}, '{1, 0, 0, 0, 0, 4}, '{1, 0, 12, 0, 0, -20}};
   int smp [4][2] = '{'{1000, -2000}, '{32767, -32768}, '{-12345, 6789}, '{0, 0}};

   // clock: 25 ns period
   always #12.5 clk = ~clk;

   iqi_datapath #(.FIFO_DEPTH(IQI_FIFO_DEPTH)) iqi_datapath_inst (.CLOCK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .IN_VALID_I(in_valid), .IN_READY_O(in_ready),
      .IN_SAMPLE_I(in_sample), .OUT_VALID_O(out_valid), .OUT_READY_I(out_ready), .OUT_SAMPLE_O(out_sample));

   iqi_stream_partner iqi_stream_partner_inst (.clk_i(clk), .stall_i(stall), .in_ready_i(in_ready),
      .in_valid_o(in_valid), .in_sample_o(in_sample), .out_valid_i(out_valid), .out_sample_i(out_sample),
      .out_ready_o(out_ready));

   // verdict, also reached by the watchdog
   task automatic results;
      if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d);
      chk({31'h0, err}, {31'h0, e});
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic e);
      apb(1'b0, a, 32'h00000000);
      chk(rd, exp);
      chk({31'h0, err}, {31'h0, e});
   endtask

   task automatic setup(input int e, input int gi, input int gq, input int oi, input int oq, input int p);
      en = e;
      cgi = gi;
      cgq = gq;
      ofi = oi;
      ofq = oq;
      ph = p;
      wr(IQI_GAIN_I_OFS, 32'(gi), 1'b0);
      wr(IQI_GAIN_Q_OFS, 32'(gq), 1'b0);
      wr(IQI_OFFS_I_OFS, 32'(oi), 1'b0);
      wr(IQI_OFFS_Q_OFS, 32'(oq), 1'b0);
      wr(IQI_PHASE_OFS, 32'(p), 1'b0);
      wr(IQI_CTRL_OFS, 32'(e), 1'b0);
      repeat (3) @(posedge clk);
   endtask

   // expected word from the current settings, q2.14 arithmetic
   function automatic logic [31:0] model(input int i, input int q);
      int gi, gq, s, c, i1, q1, i2, q2;
      if (en == 0) return {i[15:0], q[15:0]};
      gi = cgi >= 0 ? int'(IQI_GAIN_POS[cgi]) : int'(IQI_GAIN_NEG[-cgi]);
      gq = cgq >= 0 ? int'(IQI_GAIN_POS[cgq]) : int'(IQI_GAIN_NEG[-cgq]);
      s = ph >= 0 ? int'(IQI_SIN_TAB[ph]) : -int'(IQI_SIN_TAB[-ph]);
      c = int'(IQI_COS_TAB[ph >= 0 ? ph : -ph]);
      i1 = (i * gi) >>> 14;
      q1 = (q * gq) >>> 14;
      i2 = i1 - ((q1 * s) >>> 14) + ofi;
      q2 = ((q1 * c) >>> 14) + ofq;
      i2 = i2 > 32767 ? 32767 : (i2 < -32767 ? -32767 : i2);
      q2 = q2 > 32767 ? 32767 : (q2 < -32767 ? -32767 : q2);
      return {i2[15:0], q2[15:0]};
   endfunction

   task automatic send(input int i, input int q);
      iqi_sample_s s;
      s.i = 16'(i);
      s.q = 16'(q);
      iqi_stream_partner_inst.tx_q.push_back(s);
      exp_q.push_back(model(i, q));
   endtask

   // wait for every queued word, then compare in order
   task automatic drain;
      n = 0;
      while (iqi_stream_partner_inst.rx_q.size() < exp_q.size() && n < 500) begin
         @(posedge clk);
         n++;
      end
      chk(32'(iqi_stream_partner_inst.rx_q.size()), 32'(exp_q.size()));
      while (exp_q.size() > 0 && iqi_stream_partner_inst.rx_q.size() > 0) begin
         chk(iqi_stream_partner_inst.rx_q.pop_front(), exp_q.pop_front());
      end
      exp_q.delete();
      iqi_stream_partner_inst.rx_q.delete();
   endtask

   // main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      for (int a = 0; a <= 24; a += 4) rdc(8'(a), 32'h00000000, 1'b0);
      rdc(8'h1c, 32'h00000000, 1'b1);
      wr(8'h20, 32'hffffffff, 1'b1);
      wr(IQI_GAIN_I_OFS, 32'h00000014, 1'b0);
      rdc(IQI_GAIN_I_OFS, 32'h0000000c, 1'b0);
      wr(IQI_GAIN_Q_OFS, 32'hffffffe2, 1'b0);
      rdc(IQI_GAIN_Q_OFS, 32'hfffffff4, 1'b0);
      wr(IQI_PHASE_OFS, 32'h00000019, 1'b0);
      rdc(IQI_PHASE_OFS, 32'h00000014, 1'b0);
      wr(IQI_STATUS_OFS, 32'h000000ff, 1'b0);
      rdc(IQI_STATUS_OFS, 32'h00000000, 1'b0);
      for (int r = 0; r < 7; r++) begin
         setup(rows[r][0], rows[r][1], rows[r][2], rows[r][3], rows[r][4], rows[r][5]);
         foreach (smp[k]) send(smp[k][0], smp[k][1]);
         drain;
      end
      // offset with unity gain cannot fit under full scale
      setup(1, 0, 0, 2000, 0, 0);
      rdc(IQI_STATUS_OFS, 32'h00000003, 1'b0);
      setup(1, 0, 0, 0, 0, 0);
      send(100, 200);
      n = 0;
      do begin @(posedge clk); n++; end while (!(in_valid === 1'b1 && in_ready === 1'b1) && n < 50);
      n = 0;
      do begin @(posedge clk); #1; n++; end while (out_valid !== 1'b1 && n < 50);
      chk(32'(n), 32'(IQI_LATENCY));
      drain;
      // sink stalls: input refused once the credit runs out, order kept on release
      stall <= 1'b1;
      for (int k = 0; k < 10; k++) send(k * 300, -k * 200);
      repeat (20) @(posedge clk);
      chk({31'h0, in_ready}, 32'h00000000);
      chk(32'(iqi_stream_partner_inst.tx_q.size()), 32'(10 - IQI_FIFO_DEPTH));
      rdc(IQI_STATUS_OFS, 32'(IQI_FIFO_DEPTH << IQI_OCC_LSB) | 32'h00000001, 1'b0);
      stall <= 1'b0;
      drain;
      rdc(IQI_STATUS_OFS, 32'h00000001, 1'b0);
      results;
   end

   // watchdog: whole run is well under a millisecond
   initial begin
      #1000000;
      n_fail++;
      results;
   end
endmodule
`default_nettype wire
